// [parallel_gpio_upper_bank.sv]
// parallel gpio for pins 16 to 45 with an ahb-lite register slave
//
// Functional notes
// - an output pin is driven low for data bit 0 and high for data bit 1.
// - an input pin reads back 0 for a low level and 1 for a high level.
// - with its enable bit 0 a pin is released to high impedance.
// - with its enable bit 1 a pin obeys its direction and data bits.
// - direction bit 0 makes a pin an input, 1 makes it an output.
// - after reset each data bit holds the level seen on its pin.
// - bits 13 to 0 of the third bank map to pins 32 to 45, 15 and 14 spare.
// - bits 15 to 0 of the second data register map to pins 16 to 31.
// - pins 16 to 31 have own enable and direction registers, reset to 0.
//
// Design decision made here: register access over AHB-Lite.
`timescale 1ns/1ps
`include "gpio_upper_defines.svh"

module parallel_gpio_upper_bank (
  // clock, reset, enable
  input  wire logic                       sys_clk,
  input  wire logic                       rst_n,
  input  wire logic                       clkEn,
  // ahb-lite slave
  input  wire logic                       hsel,
  input  wire logic [31:0]                haddr,
  input  wire logic [1:0]                 htrans,
  input  wire logic                       hwrite,
  input  wire logic [2:0]                 hsize,
  input  wire logic                       hready,
  input  wire logic [31:0]                hwdata,
  output logic      [31:0]                hrdata,
  output logic                            hreadyout,
  output logic                            hresp,
  // pins 16 to 45, bit 0 is pin 16
  input  wire logic [`GPIO_PINS-1:0]      pinIn,
  output logic      [`GPIO_PINS-1:0]      pinOut,
  output logic      [`GPIO_PINS-1:0]      pinOe
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  gpio_upper_pkg::bus_state_e  state_ff;
  gpio_upper_pkg::bus_state_e  nxt_state;
  gpio_upper_pkg::addr_phase_s aph_ff;
  gpio_upper_pkg::addr_phase_s nxt_aph;

  logic [`GPIO_REG_W-1:0] enBank1_ff;
  logic [`GPIO_REG_W-1:0] dirBank1_ff;
  logic [`GPIO_REG_W-1:0] datBank1_ff;
  logic [`GPIO_REG_W-1:0] enBank2_ff;
  logic [`GPIO_REG_W-1:0] dirBank2_ff;
  logic [`GPIO_REG_W-1:0] datBank2_ff;

  logic [`GPIO_PINS-1:0]  pinMeta_ff;
  logic [`GPIO_PINS-1:0]  pinSync_ff;
  logic [`GPIO_PINS-1:0]  enAll;
  logic [`GPIO_PINS-1:0]  dirAll;
  logic [`GPIO_PINS-1:0]  datAll;
  logic [`GPIO_PINS-1:0]  drives;
  logic [`GPIO_PINS-1:0]  nxt_datAll;
  logic [`GPIO_PINS-1:0]  pinOut_ff;
  logic [`GPIO_PINS-1:0]  pinOe_ff;

  logic [31:0]            hrdata_ff;
  logic [31:0]            nxt_hrdata;
  logic                   takeReq;
  logic                   wrStrobe;
  logic [`GPIO_REG_W-1:0] wrWord;

  ////////////////////////////////////////////////////////////////////////////
  // functions

  // word address match against a register index
  function automatic logic hitIndex(
    input logic [31:0]            addr,
    input logic [`GPIO_REG_W-1:0] idx
  );
    logic [29:0] want;
    want = {`GPIO_WADDR_PAD, idx};
    hitIndex = (addr[`GPIO_WADDR_HI:`GPIO_WADDR_LO] == want);
  endfunction

  // address to one-hot register select
  function automatic gpio_upper_pkg::reg_sel_e decodeSel(
    input logic [31:0] addr
  );
    gpio_upper_pkg::reg_sel_e sel;
    sel = gpio_upper_pkg::SEL_NONE;
    if (hitIndex(addr, `GPIO_IDX_EN1)) begin
      sel = gpio_upper_pkg::SEL_EN1;
    end else if (hitIndex(addr, `GPIO_IDX_DIR1)) begin
      sel = gpio_upper_pkg::SEL_DIR1;
    end else if (hitIndex(addr, `GPIO_IDX_DAT1)) begin
      sel = gpio_upper_pkg::SEL_DAT1;
    end else if (hitIndex(addr, `GPIO_IDX_EN2)) begin
      sel = gpio_upper_pkg::SEL_EN2;
    end else if (hitIndex(addr, `GPIO_IDX_DIR2)) begin
      sel = gpio_upper_pkg::SEL_DIR2;
    end else if (hitIndex(addr, `GPIO_IDX_DAT2)) begin
      sel = gpio_upper_pkg::SEL_DAT2;
    end
    decodeSel = sel;
  endfunction

  // widen a register to the bus word, upper bits read as zero
  function automatic logic [31:0] toWord(
    input logic [`GPIO_REG_W-1:0] val
  );
    toWord = {`GPIO_UPPER_ZERO, val};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // bus handshake

  // a new transfer is taken only while the bus is ready and we are enabled
  assign takeReq = hsel && htrans[1] && hready && clkEn;

  always_comb begin
    nxt_aph       = aph_ff;
    nxt_aph.valid = 1'b0;
    if (takeReq) begin
      nxt_aph.valid = 1'b1;
      nxt_aph.write = hwrite && (hsize == `AHB_HSIZE_WORD);
      nxt_aph.sel   = decodeSel(haddr);
    end
  end

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      gpio_upper_pkg::ST_IDLE,
      gpio_upper_pkg::ST_WRITE,
      gpio_upper_pkg::ST_RDOUT: begin
        if (!takeReq) begin
          nxt_state = gpio_upper_pkg::ST_IDLE;
        end else if (hwrite) begin
          nxt_state = gpio_upper_pkg::ST_WRITE;
        end else begin
          nxt_state = gpio_upper_pkg::ST_RDWAIT;
        end
      end
      gpio_upper_pkg::ST_RDWAIT: begin
        nxt_state = gpio_upper_pkg::ST_RDOUT;
      end
      default: begin
        nxt_state = gpio_upper_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_ff <= gpio_upper_pkg::ST_IDLE;
    end else if (clkEn) begin
      state_ff <= nxt_state;
    end
  end

  // address phase is consumed by the data phase, never re-taken in a wait
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      aph_ff <= '{valid: 1'b0, write: 1'b0, sel: gpio_upper_pkg::SEL_NONE};
    end else if (clkEn && state_ff != gpio_upper_pkg::ST_RDWAIT) begin
      aph_ff <= nxt_aph;
    end
  end

  // one wait state on reads so that read data comes from a flop and still
  // sees a write made in the cycle before
  assign hreadyout = clkEn && (state_ff != gpio_upper_pkg::ST_RDWAIT);
  assign hresp     = `AHB_HRESP_OKAY;
  assign hrdata    = hrdata_ff;

  assign wrStrobe = clkEn && aph_ff.valid && aph_ff.write &&
                    (state_ff == gpio_upper_pkg::ST_WRITE);
  assign wrWord   = hwdata[`GPIO_REG_W-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // read path

  // unmapped addresses read as zero
  always_comb begin
    nxt_hrdata = `GPIO_RDATA_ZERO;
    unique case (aph_ff.sel)
      gpio_upper_pkg::SEL_EN1:  nxt_hrdata = toWord(enBank1_ff);
      gpio_upper_pkg::SEL_DIR1: nxt_hrdata = toWord(dirBank1_ff);
      gpio_upper_pkg::SEL_DAT1: nxt_hrdata = toWord(datBank1_ff);
      gpio_upper_pkg::SEL_EN2:  nxt_hrdata = toWord(enBank2_ff);
      gpio_upper_pkg::SEL_DIR2: nxt_hrdata = toWord(dirBank2_ff);
      gpio_upper_pkg::SEL_DAT2: nxt_hrdata = toWord(datBank2_ff);
      gpio_upper_pkg::SEL_NONE: nxt_hrdata = `GPIO_RDATA_ZERO;
      default:                  nxt_hrdata = `GPIO_RDATA_ZERO;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      hrdata_ff <= `GPIO_RDATA_ZERO;
    end else if (clkEn && state_ff == gpio_upper_pkg::ST_RDWAIT) begin
      hrdata_ff <= nxt_hrdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // enable and direction registers

  // pins 16 to 31 keep their own enable and direction words
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      enBank1_ff  <= `GPIO_CTRL_RST;
      dirBank1_ff <= `GPIO_CTRL_RST;
    end else if (wrStrobe) begin
      if (aph_ff.sel == gpio_upper_pkg::SEL_EN1) begin
        enBank1_ff <= wrWord;
      end
      if (aph_ff.sel == gpio_upper_pkg::SEL_DIR1) begin
        dirBank1_ff <= wrWord;
      end
    end
  end

  // spare bits 15 and 14 store what is written but steer nothing
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      enBank2_ff  <= `GPIO_CTRL_RST;
      dirBank2_ff <= `GPIO_CTRL_RST;
    end else if (wrStrobe) begin
      if (aph_ff.sel == gpio_upper_pkg::SEL_EN2) begin
        enBank2_ff <= wrWord;
      end
      if (aph_ff.sel == gpio_upper_pkg::SEL_DIR2) begin
        dirBank2_ff <= wrWord;
      end
    end
  end

  // flatten both banks: bit 0 is pin 16, bit 29 is pin 45
  assign enAll  = {enBank2_ff[`GPIO_BANK2_W-1:0], enBank1_ff};
  assign dirAll = {dirBank2_ff[`GPIO_BANK2_W-1:0], dirBank1_ff};
  assign datAll = {datBank2_ff[`GPIO_BANK2_W-1:0], datBank1_ff};

  // a pin is driven only when routed to gpio and set as an output
  assign drives = enAll & dirAll;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchroniser

  // no reset: the pin level itself is what reset must capture
  always_ff @(posedge sys_clk) begin
    if (clkEn) begin
      pinMeta_ff <= pinIn;
      pinSync_ff <= pinMeta_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // data registers

  // bits not driven follow the pin; written value only sticks on outputs
  always_comb begin
    nxt_datAll = (datAll & drives) | (pinSync_ff & ~drives);
    if (wrStrobe && aph_ff.sel == gpio_upper_pkg::SEL_DAT1) begin
      nxt_datAll[`GPIO_BANK1_W-1:0] =
        (wrWord & drives[`GPIO_BANK1_W-1:0]) |
        (pinSync_ff[`GPIO_BANK1_W-1:0] & ~drives[`GPIO_BANK1_W-1:0]);
    end
    if (wrStrobe && aph_ff.sel == gpio_upper_pkg::SEL_DAT2) begin
      nxt_datAll[`GPIO_BANK2_MSB:`GPIO_BANK2_LSB] =
        (wrWord[`GPIO_BANK2_W-1:0] &
         drives[`GPIO_BANK2_MSB:`GPIO_BANK2_LSB]) |
        (pinSync_ff[`GPIO_BANK2_MSB:`GPIO_BANK2_LSB] &
         ~drives[`GPIO_BANK2_MSB:`GPIO_BANK2_LSB]);
    end
  end

  // synchronous reset loads the sampled pin levels, not a constant
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      datBank1_ff <= pinSync_ff[`GPIO_BANK1_W-1:0];
    end else if (clkEn) begin
      datBank1_ff <= nxt_datAll[`GPIO_BANK1_W-1:0];
    end
  end

  // spare bits 15 and 14 of the third bank hold what software wrote
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      datBank2_ff <= {`GPIO_SPARE_RST,
                      pinSync_ff[`GPIO_BANK2_MSB:`GPIO_BANK2_LSB]};
    end else if (clkEn) begin
      datBank2_ff[`GPIO_BANK2_W-1:0] <=
        nxt_datAll[`GPIO_BANK2_MSB:`GPIO_BANK2_LSB];
      if (wrStrobe && aph_ff.sel == gpio_upper_pkg::SEL_DAT2) begin
        datBank2_ff[`GPIO_REG_W-1:`GPIO_BANK2_W] <=
          wrWord[`GPIO_REG_W-1:`GPIO_BANK2_W];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drivers

  // registered so the pads see no decode glitches
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pinOe_ff  <= `GPIO_PINS_ZERO;
      pinOut_ff <= `GPIO_PINS_ZERO;
    end else if (clkEn) begin
      pinOe_ff  <= drives;
      pinOut_ff <= datAll & drives;
    end
  end

  assign pinOe  = pinOe_ff;
  assign pinOut = pinOut_ff;

endmodule

// [gpio_upper_defines.svh]
// register indices, addresses, field layout and bus codes of the gpio bank
`ifndef GPIO_UPPER_DEFINES_SVH
`define GPIO_UPPER_DEFINES_SVH

// register indices; byte address is four times the index
`define GPIO_IDX_EN1      16'h4403
`define GPIO_IDX_DIR1     16'h4404
`define GPIO_IDX_DAT1     16'h4405
`define GPIO_IDX_EN2      16'h4406
`define GPIO_IDX_DIR2     16'h4407
`define GPIO_IDX_DAT2     16'h4408

// word address field of haddr compared against the index
`define GPIO_WADDR_HI     31
`define GPIO_WADDR_LO     2
`define GPIO_WADDR_PAD    14'h0000

// register and pin widths
`define GPIO_REG_W        16
`define GPIO_BANK1_W      16
`define GPIO_BANK2_W      14
`define GPIO_PINS         30
`define GPIO_BANK2_LSB    16
`define GPIO_BANK2_MSB    29

// reset values of control, pin, read and spare bits, and zero padding of reads
`define GPIO_CTRL_RST     16'h0000
`define GPIO_PINS_ZERO    30'h0000_0000
`define GPIO_RDATA_ZERO   32'h0000_0000
`define GPIO_UPPER_ZERO   16'h0000
`define GPIO_SPARE_RST    2'h0

// ahb codes
`define AHB_HSIZE_WORD    3'h2
`define AHB_HRESP_OKAY    1'h0

`endif

// [gpio_upper_pkg.sv]
// types shared by the upper gpio bank
package gpio_upper_pkg;

  // bus handshake state, one-hot
  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0001,
    ST_WRITE  = 4'b0010,
    ST_RDWAIT = 4'b0100,
    ST_RDOUT  = 4'b1000
  } bus_state_e;

  // decoded register select, one-hot
  typedef enum logic [6:0] {
    SEL_NONE = 7'b000_0001,
    SEL_EN1  = 7'b000_0010,
    SEL_DIR1 = 7'b000_0100,
    SEL_DAT1 = 7'b000_1000,
    SEL_EN2  = 7'b001_0000,
    SEL_DIR2 = 7'b010_0000,
    SEL_DAT2 = 7'b100_0000
  } reg_sel_e;

  // address phase held over into the data phase
  typedef struct packed {
    logic     valid;
    logic     write;
    reg_sel_e sel;
  } addr_phase_s;

endpackage

// [parallel_gpio_upper_bank_monitor.sv]
// assertion checker for the upper gpio bank ports
`timescale 1ns/1ps
`include "gpio_upper_defines.svh"
module parallel_gpio_upper_bank_monitor (
  // clock, reset, enable
  input wire logic                  sys_clk,
  input wire logic                  rst_n,
  input wire logic                  clkEn,
  // ahb-lite slave
  input wire logic                  hsel,
  input wire logic [31:0]           haddr,
  input wire logic [1:0]            htrans,
  input wire logic                  hwrite,
  input wire logic [2:0]            hsize,
  input wire logic                  hready,
  input wire logic [31:0]           hwdata,
  input wire logic [31:0]           hrdata,
  input wire logic                  hreadyout,
  input wire logic                  hresp,
  // pins
  input wire logic [`GPIO_PINS-1:0] pinIn,
  input wire logic [`GPIO_PINS-1:0] pinOut,
  input wire logic [`GPIO_PINS-1:0] pinOe
);
  logic takeW;
  logic takeR;
  assign takeW = hsel && htrans[1] && hready && clkEn && hwrite;
  assign takeR = hsel && htrans[1] && hready && clkEn && !hwrite;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  //////////////////////////////////////////////////////////////////////
  AST_WRITE_NOWAIT: assert property (takeW |=> hreadyout)
    else $error("write data phase stalled");
  AST_READ_WAIT: assert property (takeR |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  // pin drive only moves three edges after a taken write
  AST_PINOE_CAUSE: assert property ($changed(pinOe) |-> $past(takeW, 3))
    else $error("pin enable moved without a write");
  AST_PINOUT_CAUSE: assert property ($changed(pinOut) |-> $past(takeW, 3))
    else $error("pin level moved without a write");
  AST_UNDRIVEN_ZERO: assert property ((pinOut & ~pinOe) == 30'h0000_0000)
    else $error("level on an undriven pin");
  AST_HRDATA_UPPER: assert property (hrdata[31:16] == 16'h0000)
    else $error("upper read half not zero");
  AST_HRDATA_HOLD: assert property (
    $changed(hrdata) |-> !$past(hreadyout))
    else $error("read data moved outside a read");
  AST_STALL: assert property (!clkEn |-> !hreadyout)
    else $error("ready while clock disabled");
  AST_HRESP_OKAY: assert property (hresp == 1'b0)
    else $error("response not okay");
endmodule

bind parallel_gpio_upper_bank parallel_gpio_upper_bank_monitor i_mon (
  .sys_clk, .rst_n, .clkEn, .hsel, .haddr, .htrans, .hwrite, .hsize,
  .hready, .hwdata, .hrdata, .hreadyout, .hresp, .pinIn, .pinOut, .pinOe
);

// [gpio_pin_board.sv]
// board model driving the shared gpio pins
`timescale 1ns/1ps
`include "gpio_upper_defines.svh"
module gpio_pin_board (
  // device side
  input  wire logic [`GPIO_PINS-1:0] pinOut,
  input  wire logic [`GPIO_PINS-1:0] pinOe,
  // board side
  input  wire logic [`GPIO_PINS-1:0] boardLevel,
  output logic      [`GPIO_PINS-1:0] pinIn
);
  // device wins where it drives; board circuits hold the rest
  assign pinIn = (pinOe & pinOut) | (~pinOe & boardLevel);
endmodule

// [tb_parallel_gpio_upper_bank.sv]
// self-checking bench for the upper gpio bank
`timescale 1ns/1ps
`include "gpio_upper_defines.svh"
`define CHK(n, e, g) begin testsRun++; if ((g) !== (e)) begin failures++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb_parallel_gpio_upper_bank;
  logic                  sys_clk, rst_n, clkEn, hsel, hwrite;
  logic                  hreadyout, hresp;
  logic [1:0]            htrans;
  logic [2:0]            hsize;
  logic [31:0]           haddr, hwdata, hrdata, rd;
  logic [`GPIO_PINS-1:0] pinIn, pinOut, pinOe, board;
  int                    failures, testsRun;

  parallel_gpio_upper_bank i_dut (
    .sys_clk, .rst_n, .clkEn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp,
    .pinIn, .pinOut, .pinOe
  );
  gpio_pin_board i_board (.pinOut, .pinOe, .boardLevel(board), .pinIn);

  //////////////////////////////////////////////////////////////////////
  task automatic bus(input logic w, input logic [15:0] idx,
                     input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge sys_clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {14'h0000, idx, 2'b00};
    do begin @(posedge sys_clk); n++; end while (hreadyout !== 1'b1 && n < 50);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wd;
    do begin @(posedge sys_clk); n++; end while (hreadyout !== 1'b1 && n < 50);
    rd = hrdata;
    if (n >= 50) begin
      failures++;
      $display("[FAIL] bus_ready exp 1 got %b", hreadyout);
    end
  endtask

  task automatic settle(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask

  task automatic t_reset();
    settle(1);
    `CHK("oe", 30'h0000_0000, pinOe)
    bus(0, `GPIO_IDX_EN1, 0); `CHK("en1", 32'h0000_0000, rd)
    bus(0, `GPIO_IDX_DIR1, 0); `CHK("dir1", 32'h0000_0000, rd)
    bus(0, `GPIO_IDX_EN2, 0); `CHK("en2", 32'h0000_0000, rd)
    bus(0, `GPIO_IDX_DIR2, 0); `CHK("dir2", 32'h0000_0000, rd)
    bus(0, `GPIO_IDX_DAT1, 0); `CHK("dat1", {16'h0000, board[15:0]}, rd)
    bus(0, `GPIO_IDX_DAT2, 0); `CHK("dat2", {18'h0, board[29:16]}, rd)
    $display("reset test done");
  endtask

  task automatic t_bank1();
    bus(1, `GPIO_IDX_EN1, 32'h0000_00FF);
    bus(1, `GPIO_IDX_DIR1, 32'h0000_0F0F);
    bus(1, `GPIO_IDX_DAT1, 32'h0000_3C3C);
    settle(2);
    `CHK("oe1", 16'h000F, pinOe[15:0])
    `CHK("out1", 16'h000C, pinOut[15:0])
    bus(0, `GPIO_IDX_DAT1, 0);
    `CHK("rd1", {16'h0000, 16'h000C | (board[15:0] & 16'hFFF0)}, rd)
    @(posedge sys_clk);
    board <= ~board;
    settle(4);
    bus(0, `GPIO_IDX_DAT1, 0);
    `CHK("trk1", {16'h0000, 16'h000C | (board[15:0] & 16'hFFF0)}, rd)
    bus(0, `GPIO_IDX_EN1, 0); `CHK("en1rb", 32'h0000_00FF, rd)
    bus(1, `GPIO_IDX_EN1, 32'h0000_0000);
    settle(2);
    `CHK("off1", 16'h0000, pinOe[15:0])
    $display("bank1 test done");
  endtask

  task automatic t_bank2();
    bus(1, `GPIO_IDX_EN2, 32'h0000_FFFF);
    bus(1, `GPIO_IDX_DIR2, 32'h0000_C0F0);
    bus(1, `GPIO_IDX_DAT2, 32'h0000_FFFF);
    settle(2);
    `CHK("oe2", 14'h00F0, pinOe[29:16])
    `CHK("out2", 14'h00F0, pinOut[29:16])
    bus(0, `GPIO_IDX_DIR2, 0); `CHK("dir2rb", 32'h0000_C0F0, rd)
    bus(0, `GPIO_IDX_DAT2, 0);
    `CHK("rd2", {16'h0, 2'b11, 14'h00F0 | (board[29:16] & 14'h3F0F)}, rd)
    $display("bank2 test done");
  endtask

  task automatic t_misc();
    // unmapped writes must leave no trace on later reads
    bus(1, 16'h4409, 32'h0000_FFFF);
    bus(0, 16'h4409, 0); `CHK("unmap", 32'h0000_0000, rd)
    bus(0, 16'h4402, 0); `CHK("bank0", 32'h0000_0000, rd)
    @(posedge sys_clk);
    clkEn <= 1'b0;
    settle(1);
    `CHK("stall", 1'b0, hreadyout)
    @(posedge sys_clk);
    clkEn <= 1'b1;
    settle(1);
    `CHK("resume", 1'b1, hreadyout)
    `CHK("resp", 1'b0, hresp)
    $display("misc test done");
  endtask

  task automatic print_verdict();
    $display("checks %0d failures %0d", testsRun, failures);
    if (failures == 0 && testsRun > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  initial begin
    #20000;
    failures++;
    print_verdict();
  end

  initial begin
    rst_n = 1'b0;
    clkEn = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = `AHB_HSIZE_WORD;
    hwdata = 32'h0000_0000;
    board = 30'h2A5C_3C96;
    failures = 0;
    testsRun = 0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_reset();
    t_bank1();
    t_bank2();
    t_misc();
    print_verdict();
  end
endmodule
